/* File: fr_irq_status.sv */
// Purpose: upper event status bank, pending summary and interrupt line.
// Assumes: events arrive as one-cycle pulses on ref_clk; rx line clock
//          enable marks each receive line bit.
// Notes:   clear-on-read uses the read strobe itself.
`timescale 1ns/1ps
`default_nettype none
`include "fr_irq_regs.svh"

// Summary of operation
// - reading any upper status register clears all its bits
// - show-masked latches masked events, never into summary or irq
// - summary bits 0..5 show unmasked pending bits per bank
// - summary bit 6 shows pll lock, one when locked
// - errored flag set once per second when an enabled source occurred
// - tick flag set on each one-second expiry counted on rx line clock
// - prbs select 0: loopback flag on 33.16 ms detect and on loss
// - prbs select 1: loopback flag on prbs sync change, state readable
// - rx faster than system: frame skipped, skip flag, also in alarm sim
// - rx slower than system: frame repeated, repeat flag, also alarm sim
// - tx slips set repeat or skip flags, no transmit control rewrite
// - message end flags for channels b and c
// - frame start flags, two bytes after valid start
// - rx overflow flags when fifo data is lost
// - all sent flags, hdlc mode only
// - underrun aborts, transmitter disabled until status register read
// - rx pool full flags at 32 bytes of an unfinished frame
// - tx pool ready flags say a 32 byte block may be written
module fr_irq_status (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // host register port
    input wire fr_irq_pkg::host_req_t host_req,
    output logic [7:0] host_rdata,
    // event sources
    input wire fr_irq_pkg::line_evt_t line_evt,
    input wire logic rx_line_tick,
    input wire logic hdlc_mode,
    input wire fr_irq_pkg::chan_evt_t chan_b,
    input wire fr_irq_pkg::chan_evt_t chan_c,
    input wire logic [2:0] lower_pending,
    input wire logic pll_lock_pin,
    // outputs
    output logic irq,
    output logic [1:0] tx_enable,
    output logic loopback_activate_detect
);

    fr_irq_pkg::state_t st_ff;
    fr_irq_pkg::state_t nxt_st;
    logic [7:0] pend;
    logic [7:0] summary;

    // --------------------------------------------------------------------
    // helpers
    // --------------------------------------------------------------------
    // read of a given offset this cycle
    function automatic logic rd_hit(input fr_irq_pkg::host_req_t r,
                                    input logic [7:0] a);
        rd_hit = r.rd && (r.addr == a);
    endfunction

    // per-channel bit vector; hdlc gating kept here so both channels match
    function automatic logic [5:0] chan_bits(input fr_irq_pkg::chan_evt_t c,
                                             input logic hdlc);
        chan_bits = {c.msg_end, c.frame_start,
                     c.rx_overflow, c.all_sent && hdlc,
                     c.tx_underrun, c.rx_pool_full};
    endfunction

    // --------------------------------------------------------------------
    // summary and interrupt
    // --------------------------------------------------------------------
    // unmasked bits only count here, so show-masked never reaches irq
    assign pend[0] = |(st_ff.status3 & ~st_ff.mask3);
    assign pend[1] = |(st_ff.status4 & ~st_ff.mask4);
    assign pend[2] = |(st_ff.status5 & ~st_ff.mask5);
    assign pend[7:3] = 5'h0;
    assign summary = {1'b0, st_ff.pll_lock, pend[2:0], lower_pending};
    assign irq = |summary[5:0];
    assign host_rdata = st_ff.rdata;
    assign tx_enable = ~st_ff.tx_off;
    assign loopback_activate_detect = st_ff.prbs_q;

    // --------------------------------------------------------------------
    // next state
    // --------------------------------------------------------------------
    always_comb begin
        logic [7:0] set3;
        logic [7:0] set4;
        logic [7:0] set5;
        logic [7:0] vis3;
        logic [7:0] vis4;
        logic [7:0] vis5;
        logic show;
        logic sec_done;
        logic lb_pat;
        logic lb_evt;
        set3 = 8'h00;
        set4 = 8'h00;
        set5 = 8'h00;
        vis3 = 8'h00;
        vis4 = 8'h00;
        vis5 = 8'h00;
        sec_done = 1'b0;
        nxt_st = st_ff;
        show = st_ff.ctl[`CTL_SHOW_MASKED];
        lb_evt = 1'b0;
        lb_pat = line_evt.llb_act || line_evt.llb_deact;

        // one-second timer on rx line bits
        if (rx_line_tick) begin
            if (st_ff.sec_cnt == 21'(`SECOND_RX_CLKS - 1)) begin
                nxt_st.sec_cnt = 21'h0;
                sec_done = 1'b1;
            end else begin
                nxt_st.sec_cnt = st_ff.sec_cnt + 21'h1;
            end
        end
        if (|(line_evt.err_src & st_ff.errored_interval_mask[6:0])) begin
            nxt_st.err_seen = 1'b1;
        end
        if (sec_done) begin
            set3[`LES_TICK] = 1'b1;
            set3[`LES_ERRORED] = st_ff.err_seen ||
                |(line_evt.err_src & st_ff.errored_interval_mask[6:0]);
            nxt_st.err_seen = 1'b0;
        end

        // loopback pattern qualifier, counted on rx line bits
        case (st_ff.lb_state)
            fr_irq_pkg::LB_IDLE: begin
                nxt_st.lb_cnt = 16'h0;
                if (lb_pat) begin
                    nxt_st.lb_state = fr_irq_pkg::LB_QUAL;
                end
            end
            fr_irq_pkg::LB_QUAL: begin
                if (!lb_pat) begin
                    nxt_st.lb_state = fr_irq_pkg::LB_IDLE;
                end else if (rx_line_tick) begin
                    if (st_ff.lb_cnt == 16'(`LOOPBACK_DETECT_CLKS - 1)) begin
                        nxt_st.lb_state = fr_irq_pkg::LB_HELD;
                        lb_evt = 1'b1;
                    end else begin
                        nxt_st.lb_cnt = st_ff.lb_cnt + 16'h1;
                    end
                end
            end
            fr_irq_pkg::LB_HELD: begin
                if (!lb_pat) begin
                    nxt_st.lb_state = fr_irq_pkg::LB_IDLE;
                    lb_evt = 1'b1;
                end
            end
            default: begin
                nxt_st.lb_state = fr_irq_pkg::LB_IDLE;
            end
        endcase
        nxt_st.prbs_q = line_evt.prbs_sync;
        if (st_ff.ctl[`CTL_PRBS_SELECT]) begin
            set3[`LES_LOOPBACK] = line_evt.prbs_sync ^ st_ff.prbs_q;
        end else begin
            set3[`LES_LOOPBACK] = lb_evt;
        end

        // slips; alarm simulation forces both receive slips
        set3[`LES_RX_SKIP] = line_evt.rx_skip || line_evt.alarm_sim;
        set3[`LES_RX_REPEAT] = line_evt.rx_repeat ||
            line_evt.alarm_sim;
        set4[`SC_TX_REPEAT] = line_evt.tx_repeat;
        set4[`SC_TX_SKIP] = line_evt.tx_skip;

        // hdlc channel events
        set4[5:0] = chan_bits(chan_b, hdlc_mode);
        set5[5:0] = chan_bits(chan_c, hdlc_mode);
        set5[`C3_TX_POOL_B] = chan_b.tx_pool_ready;
        set5[`C3_TX_POOL_C] = chan_c.tx_pool_ready;

        // masked events dropped unless show-masked is set
        vis3 = show ? set3 : (set3 & ~st_ff.mask3);
        vis4 = show ? set4 : (set4 & ~st_ff.mask4);
        vis5 = show ? set5 : (set5 & ~st_ff.mask5);

        // clear on read, then set; a new event wins over the clear
        nxt_st.status3 = (rd_hit(host_req, `LINE_EVENT_STATUS_ADDR) ?
            `STATUS_RESET : st_ff.status3) | vis3;
        nxt_st.status4 = (rd_hit(host_req, `SLIP_CHAN2_STATUS_ADDR) ?
            `STATUS_RESET : st_ff.status4) | vis4;
        nxt_st.status5 = (rd_hit(host_req, `CHAN3_EVENT_STATUS_ADDR) ?
            `STATUS_RESET : st_ff.status5) | vis5;

        // underrun holds transmitter off until its status register is read
        if (rd_hit(host_req, `SLIP_CHAN2_STATUS_ADDR)) begin
            nxt_st.tx_off[0] = 1'b0;
        end
        if (rd_hit(host_req, `CHAN3_EVENT_STATUS_ADDR)) begin
            nxt_st.tx_off[1] = 1'b0;
        end
        if (chan_b.tx_underrun) begin
            nxt_st.tx_off[0] = 1'b1;
        end
        if (chan_c.tx_underrun) begin
            nxt_st.tx_off[1] = 1'b1;
        end

        // pll lock through three flops, change once last two agree
        nxt_st.pll_sync = {st_ff.pll_sync[1:0], pll_lock_pin};
        if (st_ff.pll_sync[2] == st_ff.pll_sync[1]) begin
            nxt_st.pll_lock = st_ff.pll_sync[2];
        end

        // register writes
        if (host_req.wr) begin
            case (host_req.addr)
                `BANK3_MASK_ADDR: nxt_st.mask3 = host_req.wdata;
                `BANK4_MASK_ADDR: nxt_st.mask4 = host_req.wdata;
                `BANK5_MASK_ADDR: nxt_st.mask5 = host_req.wdata;
                `ERR_INTERVAL_MASK_ADDR: nxt_st.errored_interval_mask = host_req.wdata;
                `CONTROL_ADDR: nxt_st.ctl = host_req.wdata;
                default: nxt_st.ctl = st_ff.ctl;
            endcase
        end

        // read data, valid the cycle after the strobe only
        nxt_st.rdata = 8'h00;
        if (host_req.rd) begin
            case (host_req.addr)
                `LINE_EVENT_STATUS_ADDR: nxt_st.rdata = st_ff.status3;
                `SLIP_CHAN2_STATUS_ADDR: nxt_st.rdata = st_ff.status4;
                `CHAN3_EVENT_STATUS_ADDR: nxt_st.rdata = st_ff.status5;
                `GLOBAL_PENDING_ADDR: nxt_st.rdata = summary;
                `BANK3_MASK_ADDR: nxt_st.rdata = st_ff.mask3;
                `BANK4_MASK_ADDR: nxt_st.rdata = st_ff.mask4;
                `BANK5_MASK_ADDR: nxt_st.rdata = st_ff.mask5;
                `ERR_INTERVAL_MASK_ADDR: nxt_st.rdata = st_ff.errored_interval_mask;
                `CONTROL_ADDR: nxt_st.rdata = st_ff.ctl;
                default: nxt_st.rdata = 8'h00;
            endcase
        end
    end

    // --------------------------------------------------------------------
    // state register
    // --------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            st_ff <= '0;
            st_ff.mask3 <= `MASK_RESET;
            st_ff.mask4 <= `MASK_RESET;
            st_ff.mask5 <= `MASK_RESET;
            st_ff.errored_interval_mask <= `ESM_RESET;
            st_ff.ctl <= `CTL_RESET;
            st_ff.lb_state <= fr_irq_pkg::LB_IDLE;
        end else begin
            st_ff <= nxt_st;
        end
    end

endmodule
`default_nettype wire

/* File: fr_irq_regs.svh */
// Purpose: offsets, field positions and timing counts for the upper
//          event status bank and the pending summary.
// Assumes: byte-wide registers on a plain address/strobe port.
// Notes:   definitions only.
`ifndef FR_IRQ_REGS_SVH
`define FR_IRQ_REGS_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define LINE_EVENT_STATUS_ADDR 8'h6B
`define SLIP_CHAN2_STATUS_ADDR 8'h6C
`define CHAN3_EVENT_STATUS_ADDR 8'h6D
`define GLOBAL_PENDING_ADDR 8'h6E
`define BANK3_MASK_ADDR 8'hE0
`define BANK4_MASK_ADDR 8'hE1
`define BANK5_MASK_ADDR 8'hE2
`define ERR_INTERVAL_MASK_ADDR 8'hE3
`define CONTROL_ADDR 8'hE4

// ----------------------------------------------------------------------
// line event status fields
// ----------------------------------------------------------------------
`define LES_ERRORED 7
`define LES_TICK 6
`define LES_LOOPBACK 3
`define LES_RX_SKIP 1
`define LES_RX_REPEAT 0

// ----------------------------------------------------------------------
// slip and channel status fields (channel b in bank 4, c in bank 5, both tx pool ready flags in bank 5)
// ----------------------------------------------------------------------
`define SC_TX_REPEAT 7
`define SC_TX_SKIP 6
`define CH_MSG_END 5
`define CH_FRAME_START 4
`define CH_RX_OVERFLOW 3
`define CH_ALL_SENT 2
`define CH_TX_UNDERRUN 1
`define CH_RX_POOL_FULL 0
`define C3_TX_POOL_B 7
`define C3_TX_POOL_C 6

// ----------------------------------------------------------------------
// control fields, summary and reset values
// ----------------------------------------------------------------------
`define CTL_SHOW_MASKED 0
`define CTL_PRBS_SELECT 1
`define GPS_PLL_LOCK 6
`define MASK_RESET 8'hFF
`define ESM_RESET 8'h00
`define CTL_RESET 8'h00
`define STATUS_RESET 8'h00

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define SECOND_RX_CLKS 1544000
`define LOOPBACK_DETECT_US 33160
`define RX_CLK_KHZ 1544
`define LOOPBACK_DETECT_CLKS ((`LOOPBACK_DETECT_US * `RX_CLK_KHZ) / 1000)

`endif

/* File: fr_irq_pkg.sv */
// Purpose: types for the upper event status block.
// Assumes: constants live in fr_irq_regs.svh.
// Notes:   no import; use fr_irq_pkg::name.
package fr_irq_pkg;

    // host register port
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } host_req_t;

    // per-channel hdlc events
    typedef struct packed {
        logic msg_end;
        logic frame_start;
        logic rx_overflow;
        logic all_sent;
        logic tx_underrun;
        logic rx_pool_full;
        logic tx_pool_ready;
    } chan_evt_t;

    // line side events and levels
    typedef struct packed {
        logic [6:0] err_src;
        logic rx_skip;
        logic rx_repeat;
        logic tx_repeat;
        logic tx_skip;
        logic alarm_sim;
        logic llb_act;
        logic llb_deact;
        logic prbs_sync;
    } line_evt_t;

    // loopback qualifier states, gray along the usual path
    typedef enum logic [1:0] {
        LB_IDLE = 2'b00,
        LB_QUAL = 2'b01,
        LB_HELD = 2'b11
    } lb_state_t;

    // complete block state
    typedef struct packed {
        logic [7:0] status3;
        logic [7:0] status4;
        logic [7:0] status5;
        logic [7:0] mask3;
        logic [7:0] mask4;
        logic [7:0] mask5;
        logic [7:0] errored_interval_mask;
        logic [7:0] ctl;
        logic [7:0] rdata;
        logic [20:0] sec_cnt;
        logic err_seen;
        lb_state_t lb_state;
        logic [15:0] lb_cnt;
        logic prbs_q;
        logic [1:0] tx_off;
        logic [2:0] pll_sync;
        logic pll_lock;
    } state_t;

endpackage

/* File: fr_irq_status_monitor.sv */
// Purpose: port checker for the upper event status block.
// Assumes: masks reset to all masked; events are one-cycle pulses.
// Notes:   bound into every fr_irq_status instance.
`timescale 1ns/1ps
`default_nettype none
`include "fr_irq_regs.svh"
module fr_irq_status_monitor (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // host port
    input wire fr_irq_pkg::host_req_t host_req,
    input wire logic [7:0] host_rdata,
    // event sources
    input wire fr_irq_pkg::line_evt_t line_evt,
    input wire logic rx_line_tick,
    input wire logic hdlc_mode,
    input wire fr_irq_pkg::chan_evt_t chan_b,
    input wire fr_irq_pkg::chan_evt_t chan_c,
    input wire logic [2:0] lower_pending,
    input wire logic pll_lock_pin,
    // block outputs
    input wire logic irq,
    input wire logic [1:0] tx_enable,
    input wire logic loopback_activate_detect
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    logic mapped;
    logic mask_wr_ff;
    logic nxt_mask_wr;
    logic [20:0] tick_cnt_ff;
    logic [20:0] nxt_tick_cnt;
    // addresses that answer; anything else must read as zero
    assign mapped = host_req.addr inside {[8'h6B:8'h6E], [8'hE0:8'hE4]};
    // until a mask is written every bank stays masked
    assign nxt_mask_wr = reset_n && (mask_wr_ff || (host_req.wr
        && host_req.addr inside {[8'hE0:8'hE2]}));
    // rx line bits since reset, held once a second has gone by
    assign nxt_tick_cnt = !reset_n ? 21'h0 : (tick_cnt_ff
        + 21'(rx_line_tick && tick_cnt_ff < 21'(`SECOND_RX_CLKS)));
    always_ff @(posedge ref_clk) begin
        mask_wr_ff <= nxt_mask_wr;
        tick_cnt_ff <= nxt_tick_cnt;
    end
    // register read, optionally with the line events quiet
    sequence rd_of(logic [7:0] a);
        host_req.rd && host_req.addr == a;
    endsequence
    sequence quiet_rd(logic [7:0] a);
        rd_of(a) ##0 line_evt == '0;
    endsequence
    clear_read_a: assert property ($past(line_evt) == '0
        ##0 quiet_rd(8'h6B) ##1 line_evt == '0 ##1 quiet_rd(8'h6B)
        |=> host_rdata == 8'h00) else $error("status kept after read");
    masked_quiet_a: assert property (
        !mask_wr_ff |-> irq == (|lower_pending))
        else $error("masked event reached irq");
    irq_lower_a: assert property (|lower_pending |-> irq)
        else $error("irq low with lower bank pending");
    gis_lower_a: assert property (rd_of(8'h6E)
        |=> host_rdata[2:0] == $past(lower_pending))
        else $error("summary low bits wrong");
    gis_top_a: assert property (rd_of(8'h6E) |=> !host_rdata[7])
        else $error("summary bit 7 set");
    pll_high_a: assert property (pll_lock_pin[*6]
        ##0 rd_of(8'h6E) |=> host_rdata[6]) else $error("lock not shown");
    pll_low_a: assert property ((!pll_lock_pin)[*6]
        ##0 rd_of(8'h6E) |=> !host_rdata[6]) else $error("unlock not shown");
    under_b_a: assert property (chan_b.tx_underrun |=> !tx_enable[0])
        else $error("channel b kept enabled");
    under_c_a: assert property (chan_c.tx_underrun |=> !tx_enable[1])
        else $error("channel c kept enabled");
    back_b_a: assert property ($past(reset_n) && $rose(tx_enable[0])
        |-> $past(host_req.rd) && $past(host_req.addr) == 8'h6C)
        else $error("channel b enabled without read");
    back_c_a: assert property ($past(reset_n) && $rose(tx_enable[1])
        |-> $past(host_req.rd) && $past(host_req.addr) == 8'h6D)
        else $error("channel c enabled without read");
    prbs_view_a: assert property (
        line_evt.prbs_sync != loopback_activate_detect
        |=> loopback_activate_detect == $past(line_evt.prbs_sync))
        else $error("prbs state not shown");
    unmapped_a: assert property (host_req.rd && !mapped
        |=> host_rdata == 8'h00) else $error("unmapped read not zero");
    // second and errored flags only once a full second of bits went by
    early_tick_a: assert property (rd_of(8'h6B)
        ##0 tick_cnt_ff < 21'(`SECOND_RX_CLKS)
        |=> host_rdata[7:6] == 2'b00)
        else $error("second flags before expiry");
endmodule
bind fr_irq_status fr_irq_status_monitor u_monitor (
    .ref_clk(ref_clk), .reset_n(reset_n), .host_req(host_req),
    .host_rdata(host_rdata), .line_evt(line_evt),
    .rx_line_tick(rx_line_tick), .hdlc_mode(hdlc_mode), .chan_b(chan_b),
    .chan_c(chan_c), .lower_pending(lower_pending),
    .pll_lock_pin(pll_lock_pin), .irq(irq), .tx_enable(tx_enable),
    .loopback_activate_detect(loopback_activate_detect));
`default_nettype wire

/* File: fr_host_model.sv */
// Purpose: host processor model on the register port.
// Assumes: slave never stalls; read data valid one cycle after strobe.
// Notes:   tasks are called from the bench.
`timescale 1ns/1ps
`default_nettype none
module fr_host_model (
    // clock
    input wire logic ref_clk,
    // register port
    output var fr_irq_pkg::host_req_t host_req,
    input wire logic [7:0] host_rdata
);
    initial host_req = '0;
    // one strobe cycle, released after the edge that takes it
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        host_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk);
        host_req.wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        host_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk);
        host_req.rd <= 1'b0;
        #1 d = host_rdata;
    endtask
    // underrun stays unmasked: the transmitter waits on our read
    task automatic set_mask(input logic [7:0] a, input logic [7:0] m);
        wr(a, (a == 8'hE0) ? m : (m & 8'hFD));
    endtask
endmodule
`default_nettype wire

/* File: tb_top.sv */
// Purpose: self-checking bench for the upper event status block.
// Assumes: rx line tick held high, one line bit per clock.
// Notes:   the long loopback qualification runs last.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) \
    begin \
        checked++; \
        if ((got) !== (exp)) begin \
            failures++; \
            $display("Error %s expected %h seen %h", nm, exp, got); \
        end \
    end
module tb_top;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    fr_irq_pkg::host_req_t host_req;
    logic [7:0] host_rdata;
    fr_irq_pkg::line_evt_t line_evt = '0;
    logic rx_line_tick = 1'b1;
    logic hdlc_mode = 1'b1;
    fr_irq_pkg::chan_evt_t chan_b = '0;
    fr_irq_pkg::chan_evt_t chan_c = '0;
    logic [2:0] lower_pending = 3'h0;
    logic pll_lock_pin = 1'b0;
    logic irq;
    logic [1:0] tx_enable;
    logic loopback_activate_detect;
    int failures = 0;
    int checked = 0;
    always #4 ref_clk = ~ref_clk;
    fr_irq_status DUT (.ref_clk(ref_clk), .reset_n(reset_n),
        .host_req(host_req), .host_rdata(host_rdata), .line_evt(line_evt),
        .rx_line_tick(rx_line_tick), .hdlc_mode(hdlc_mode),
        .chan_b(chan_b), .chan_c(chan_c), .lower_pending(lower_pending),
        .pll_lock_pin(pll_lock_pin), .irq(irq), .tx_enable(tx_enable),
        .loopback_activate_detect(loopback_activate_detect));
    fr_host_model u_host (.ref_clk(ref_clk), .host_req(host_req),
        .host_rdata(host_rdata));
    task automatic stop_test;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        u_host.rd(a, d);
        `CHK($sformatf("reg %h", a), e, d)
    endtask
    // second read must find the register empty
    task automatic rd2(input logic [7:0] a, input logic [7:0] e);
        rd_chk(a, e);
        rd_chk(a, 8'h00);
    endtask
    // one-cycle pulse; levels in line_evt are dropped too
    task automatic pulse_line(input int b);
        @(posedge ref_clk);
        line_evt <= fr_irq_pkg::line_evt_t'(15'(1) << b);
        @(posedge ref_clk);
        line_evt <= '0;
        #1;
    endtask
    // upper seven bits to channel b, lower seven to channel c
    task automatic pulse_chan(input logic [13:0] v);
        @(posedge ref_clk);
        chan_b <= fr_irq_pkg::chan_evt_t'(v[13:7]);
        chan_c <= fr_irq_pkg::chan_evt_t'(v[6:0]);
        @(posedge ref_clk);
        chan_b <= '0;
        chan_c <= '0;
        #1;
    endtask
    task automatic t_reset;
        logic [7:0] addr [5] = '{8'h6B, 8'h6C, 8'h6D, 8'h6E, 8'h10};
        foreach (addr[i]) begin
            rd_chk(addr[i], 8'h00);
        end
        @(posedge ref_clk);
        lower_pending <= 3'h5;
        @(posedge ref_clk);
        #1;
        `CHK("irq", 1'b1, irq)
        rd_chk(8'h6E, 8'h05);
        @(posedge ref_clk);
        lower_pending <= 3'h0;
    endtask
    task automatic t_mask;
        pulse_line(7);
        rd_chk(8'h6B, 8'h00);
        u_host.wr(8'hE4, 8'h01);
        pulse_line(7);
        `CHK("irq", 1'b0, irq)
        rd_chk(8'h6E, 8'h00);
        rd_chk(8'h6B, 8'h02);
        u_host.set_mask(8'hE0, 8'h00);
        pulse_line(6);
        `CHK("irq", 1'b1, irq)
        rd_chk(8'h6E, 8'h08);
        rd_chk(8'h6B, 8'h01);
        `CHK("irq", 1'b0, irq)
        pulse_line(3);
        rd2(8'h6B, 8'h03);
        // errored flag waits for the end of the interval
        u_host.wr(8'hE3, 8'h7F);
        rd_chk(8'hE3, 8'h7F);
        pulse_line(8);
        rd_chk(8'h6B, 8'h00);
    endtask
    task automatic t_chan;
        logic [7:0] a;
        logic [7:0] e;
        pulse_line(5);
        rd2(8'h6C, 8'h80);
        pulse_line(4);
        rd2(8'h6C, 8'h40);
        // field 0 is pool ready, kept apart in bank 5
        for (int k = 0; k < 14; k++) begin
            a = (k >= 7 || k == 0) ? 8'h6D : 8'h6C;
            e = (k == 0) ? 8'h80 : (k == 7) ? 8'h40 : 8'h01 << (k % 7 - 1);
            pulse_chan(k < 7 ? 14'h0080 << k : 14'h0001 << (k - 7));
            rd2(a, e);
        end
        @(posedge ref_clk);
        hdlc_mode <= 1'b0;
        pulse_chan(14'h0400);
        rd_chk(8'h6C, 8'h00);
    endtask
    task automatic t_under;
        u_host.set_mask(8'hE1, 8'h00);
        u_host.set_mask(8'hE2, 8'h00);
        pulse_chan(14'h0200);
        `CHK("tx_enable", 2'b10, tx_enable)
        `CHK("irq", 1'b1, irq)
        rd_chk(8'h6E, 8'h10);
        `CHK("tx_enable", 2'b10, tx_enable)
        rd_chk(8'h6C, 8'h02);
        `CHK("tx_enable", 2'b11, tx_enable)
        `CHK("irq", 1'b0, irq)
        pulse_chan(14'h0004);
        `CHK("tx_enable", 2'b01, tx_enable)
        rd_chk(8'h6E, 8'h20);
        rd_chk(8'h6D, 8'h02);
        `CHK("tx_enable", 2'b11, tx_enable)
        `CHK("irq", 1'b0, irq)
    endtask
    task automatic t_prbs;
        u_host.wr(8'hE4, 8'h03);
        for (int v = 1; v >= 0; v--) begin
            @(posedge ref_clk);
            line_evt.prbs_sync <= 1'(v);
            repeat (3) @(posedge ref_clk);
            #1;
            `CHK("prbs state", 1'(v), loopback_activate_detect)
            rd_chk(8'h6B, 8'h08);
        end
        u_host.wr(8'hE4, 8'h01);
    endtask
    // detect qualifies after 33.16 ms of line bits; loss flags at once
    task automatic t_loop;
        @(posedge ref_clk);
        pll_lock_pin <= 1'b1;
        line_evt.llb_act <= 1'b1;
        repeat (51000) @(posedge ref_clk);
        rd_chk(8'h6E, 8'h40);
        rd_chk(8'h6B, 8'h00);
        repeat (400) @(posedge ref_clk);
        rd_chk(8'h6B, 8'h08);
        @(posedge ref_clk);
        line_evt.llb_act <= 1'b0;
        repeat (4) @(posedge ref_clk);
        rd_chk(8'h6B, 8'h08);
    endtask
    initial begin
        repeat (5) @(posedge ref_clk);
        reset_n <= 1'b1;
        t_reset();
        t_mask();
        t_chan();
        t_under();
        t_prbs();
        t_loop();
        stop_test();
    end
    // hang guard
    initial begin
        repeat (100000) @(posedge ref_clk);
        failures++;
        stop_test();
    end
endmodule
`default_nettype wire
